/* rx_port_pkg.sv */
// Purpose: Shared constants and types of the receive parallel output port.
// Assumes: One system clock; clock-source edges arrive as one-cycle ticks.
// Notes: Field positions describe the raw character and the status word.
`default_nettype none
package rx_port_pkg;

  localparam int RAW_W = 10;
  localparam int DATA_W = 8;
  localparam int STAT_W = 3;
  localparam int FIFO_DEPTH = 4;

  // Raw character split in decoder-bypass mode
  localparam int RAW_HIGH_LSB = 2;
  localparam int RAW_LOW_W = 2;
  localparam int STAT_COMMA_BIT = 2;

  // Configuration latch encodings
  localparam logic SRC_RECOVERED = 1'b0;
  localparam logic SRC_REFERENCE = 1'b1;
  localparam logic RATE_FULL = 1'b0;
  localparam logic RATE_HALF = 1'b1;

  // Reset values of the configuration latches
  localparam logic CLK_SRC_RST = 1'b0;
  localparam logic RATE_RST = 1'b0;
  localparam logic REF_HALF_RST = 1'b0;
  localparam logic BYPASS_RST = 1'b0;

  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;

  // How the interface clock is built from the selected source
  typedef enum logic [2:0] {
    CLK_MODE_FOLLOW = 3'b001,
    CLK_MODE_DIVIDE = 3'b010,
    CLK_MODE_REFCOPY = 3'b100
  } clk_mode_t;

endpackage : rx_port_pkg
`default_nettype wire

/* rx_clock_if.sv */
// Purpose: Carries source edges and mode to the clock stage, and its outputs.
// Assumes: All signals are synchronous to the system clock.
// Notes: The control side drives ticks and mode; the stage returns levels and the update strobe.
`timescale 1ns/1ps
`default_nettype none
interface rx_clock_if;
  import rx_port_pkg::*;
  logic edge_tick;
  logic edge_rise;
  clk_mode_t mode;
  logic clk_level;
  logic clk_level_n;
  logic char_strobe;

  modport ctrl (
    output edge_tick, edge_rise, mode,
    input clk_level, clk_level_n, char_strobe
  );
  modport stage (
    input edge_tick, edge_rise, mode,
    output clk_level, clk_level_n, char_strobe
  );
endinterface : rx_clock_if
`default_nettype wire

/* rx_char_fifo.sv */
// Purpose: Small character buffer between the decoder and the output register.
// Assumes: Drain side may stall; fill side must honour in_ready.
// Notes: in_ready is a register so it can reach a top-level pin directly.
`timescale 1ns/1ps
`default_nettype none
module rx_char_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain takes word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg, wr_ptr_next, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic ready_reg;
  wire push = in_valid & ready_reg;
  wire pop = out_valid & out_ready;

  assign wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                       : wr_ptr_reg + PTR_W'(1);
  assign rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                       : rd_ptr_reg + PTR_W'(1);
  assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  assign in_ready = ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_next;
      if (pop) rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= (count_next != CNT_W'(DEPTH));
    end
  end

  // Storage needs no reset; pointers guard stale words
  always_ff @(posedge clk) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule : rx_char_fifo
`default_nettype wire

/* rx_clock_stage.sv */
// Purpose: Builds the true and complement interface clock and the update strobe.
// Assumes: edge_tick marks each edge of the selected source clock.
// Notes: Clock levels are registered in the same edge as the data register.
`timescale 1ns/1ps
`default_nettype none
module rx_clock_stage
  import rx_port_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  rx_clock_if.stage link // Source ticks in, clock levels out
);
  logic level_reg, level_next;
  logic level_n_reg;
  wire rise_tick = link.edge_tick & link.edge_rise;
  wire follow_level = link.edge_tick ? link.edge_rise : level_reg;
  wire divide_level = rise_tick ? ~level_reg : level_reg;

  // Divide halves the rate; follow and copy track the source edges
  assign level_next = (link.mode == CLK_MODE_DIVIDE) ? divide_level
                      : follow_level;
  // Half-rate copy of the reference updates data on every edge
  assign link.char_strobe = (link.mode == CLK_MODE_REFCOPY) ? link.edge_tick
                            : rise_tick;
  assign link.clk_level = level_reg;
  assign link.clk_level_n = level_n_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 1'b0;
      level_n_reg <= 1'b1;
    end else begin
      level_reg <= level_next;
      level_n_reg <= ~level_next;
    end
  end
endmodule : rx_clock_stage
`default_nettype wire

/* rx_parallel_output_port.sv */
// Purpose: Receive parallel output port of one channel: data, status, clocks.
// Assumes: Source clock edges, decoder results and config writes arrive on CLK.
// Notes: A FIFO decouples decoder timing from the output clock strobe.
//
// Overview of operation
// R1 - Data outputs change only in step with the selected interface clock.
// R2 - A configuration latch chooses the source of the interface clock.
// R3 - At full rate the clock runs at character rate, data on the true rise.
// R4 - At half rate the clock runs at half character rate, data on both edges.
// R5 - In bypass the two low raw bits appear on the two low status bits.
// R6 - In bypass the top status bit flags a comma in the output register.
// R7 - With the decoder on, the status bits carry the decoder status code.
// R8 - Outside the R12 case, the clocks run continuously at the rate chosen by the rate latch.
// R9 - From the reference, the clock out is a copy or divided copy of it.
// R10 - A full-rate reference leaves the output rate to the rate latch.
// R11 - A half-rate reference with source zero leaves rate to the rate latch.
// R12 - A half-rate reference with source one runs at reference rate.
// R13 - Host logic may capture with either the reference or output clock.
// R14 - Source latch zero selects the clock recovered from the serial data.
// R15 - A half-rate reference updates outputs on both reference edges.
// R16 - Bypass puts the upper eight raw bits on data, else decoded data.
`timescale 1ns/1ps
`default_nettype none
module rx_parallel_output_port
  import rx_port_pkg::*;
#(
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input wire logic CLK, // System clock, 40 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic REC_EDGE_TICK, // Recovered clock edge seen
  input wire logic REC_EDGE_RISE, // That edge was rising
  input wire logic REF_EDGE_TICK, // Reference clock edge seen
  input wire logic REF_EDGE_RISE, // That edge was rising
  input wire logic CFG_WRITE, // Load configuration latches
  input wire logic CFG_CLK_SRC_SEL, // 0 recovered, 1 reference
  input wire logic CFG_RATE_SEL, // 0 character, 1 dual-character
  input wire logic CFG_REFCLK_HALF, // Reference runs at half rate
  input wire logic CFG_DECODER_BYPASS, // Pass raw characters
  input wire logic RX_IN_VALID, // Received character offered
  output logic RX_IN_READY, // Buffer can take it
  input wire logic [RAW_W-1:0] RX_IN_RAW, // Raw 10-bit character
  input wire logic [DATA_W-1:0] RX_IN_DECODED, // Decoded character
  input wire logic [STAT_W-1:0] RX_IN_STATUS_CODE, // Decoder status
  input wire logic RX_IN_IS_COMMA, // Raw character is a comma
  output logic [DATA_W-1:0] RX_PARALLEL_DATA, // Received data
  output logic [STAT_W-1:0] RX_CHAR_STATUS, // Received status
  output logic RX_INTERFACE_CLOCK_OUT_TRUE, // Interface clock, true
  output logic RX_INTERFACE_CLOCK_OUT_COMP, // Interface clock, complement
  output logic RX_CLOCK_SOURCE_SELECT, // Source latch value
  output logic RX_CLOCK_RATE_SELECT, // Rate latch value
  output logic RX_CHAR_MISSED // Strobe found buffer empty
);
  localparam int WORD_W = DATA_W + STAT_W;

  // Configuration latches
  logic src_sel_reg, rate_sel_reg, ref_half_reg, bypass_reg;
  // Output register
  logic [DATA_W-1:0] data_reg, data_next;
  logic [STAT_W-1:0] stat_reg, stat_next;
  logic missed_reg, missed_next;

  rx_clock_if clk_link ();

  // Buffer traffic
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic [WORD_W-1:0] fifo_in_data;

  // Character formatting at the buffer input
  wire [DATA_W-1:0] bypass_data = RX_IN_RAW[RAW_HIGH_LSB +: DATA_W];
  wire [STAT_W-1:0] bypass_stat = {RX_IN_IS_COMMA,
                                   RX_IN_RAW[RAW_LOW_W-1:0]};
  wire [DATA_W-1:0] char_data = bypass_reg ? bypass_data
                                : RX_IN_DECODED; // see R16
  // Comma flag rides with its own character into the output register
  wire [STAT_W-1:0] char_stat = bypass_reg ? bypass_stat // see R5 see R6
                                : RX_IN_STATUS_CODE; // see R7
  assign fifo_in_data = {char_data, char_stat};

  // Clock source and mode selection
  wire use_reference = (src_sel_reg == SRC_REFERENCE);
  wire ref_copy = use_reference & ref_half_reg; // see R12
  wire half_out = (rate_sel_reg == RATE_HALF);
  wire src_tick = use_reference ? REF_EDGE_TICK // see R2 see R9
                  : REC_EDGE_TICK; // see R14
  wire src_rise = use_reference ? REF_EDGE_RISE : REC_EDGE_RISE;
  // Rate latch ignored only for a half-rate reference copy
  wire [2:0] mode_bits = ref_copy ? CLK_MODE_REFCOPY // see R12 see R15
                         : half_out ? CLK_MODE_DIVIDE // see R4 see R8
                         : CLK_MODE_FOLLOW; // see R3 see R10 see R11

  assign clk_link.edge_tick = src_tick;
  assign clk_link.edge_rise = src_rise;
  assign clk_link.mode = clk_mode_t'(mode_bits);

  rx_clock_stage u_clock_stage (
    .clk (CLK),
    .rst (RST),
    .link (clk_link.stage)
  );

  rx_char_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_char_fifo (
    .clk (CLK),
    .rst (RST),
    .in_valid (RX_IN_VALID),
    .in_ready (fifo_in_ready),
    .in_data (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (clk_link.char_strobe),
    .out_data (fifo_out_data)
  );

  // Output register loads only on the interface clock strobe
  wire strobe = clk_link.char_strobe;
  wire take = strobe & fifo_out_valid;
  assign data_next = take ? fifo_out_data[STAT_W +: DATA_W]
                     : data_reg; // see R1
  assign stat_next = take ? fifo_out_data[STAT_W-1:0] : stat_reg;
  // Empty buffer at a strobe holds the last character and flags it
  assign missed_next = strobe ? ~fifo_out_valid : missed_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      src_sel_reg <= CLK_SRC_RST;
      rate_sel_reg <= RATE_RST;
      ref_half_reg <= REF_HALF_RST;
      bypass_reg <= BYPASS_RST;
    end else if (CFG_WRITE) begin
      src_sel_reg <= CFG_CLK_SRC_SEL; // see R2
      rate_sel_reg <= CFG_RATE_SEL;
      ref_half_reg <= CFG_REFCLK_HALF;
      bypass_reg <= CFG_DECODER_BYPASS;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      data_reg <= DATA_RST;
      stat_reg <= STAT_RST;
      missed_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      stat_reg <= stat_next;
      missed_reg <= missed_next;
    end
  end

  assign RX_IN_READY = fifo_in_ready;
  assign RX_PARALLEL_DATA = data_reg;
  assign RX_CHAR_STATUS = stat_reg;
  assign RX_INTERFACE_CLOCK_OUT_TRUE = clk_link.clk_level;
  assign RX_INTERFACE_CLOCK_OUT_COMP = clk_link.clk_level_n;
  assign RX_CLOCK_SOURCE_SELECT = src_sel_reg;
  assign RX_CLOCK_RATE_SELECT = rate_sel_reg;
  assign RX_CHAR_MISSED = missed_reg;
endmodule : rx_parallel_output_port
`default_nettype wire

/* rx_port_properties.sv */
// Purpose: Timing checks on the receive port clock, data and latch outputs.
// Assumes: Source edges arrive as one-cycle ticks on CLK.
// Notes: No port shows the half-rate reference latch, so it is mirrored here.
`timescale 1ns/1ps
`default_nettype none
module rx_port_properties
  import rx_port_pkg::*;
(
  input wire logic CLK, // System clock
  input wire logic RST, // Synchronous reset
  input wire logic REC_EDGE_TICK, // Recovered edge
  input wire logic REC_EDGE_RISE, // Recovered edge rising
  input wire logic REF_EDGE_TICK, // Reference edge
  input wire logic REF_EDGE_RISE, // Reference edge rising
  input wire logic CFG_WRITE, // Latch load
  input wire logic CFG_CLK_SRC_SEL, // Source bit
  input wire logic CFG_RATE_SEL, // Rate bit
  input wire logic CFG_REFCLK_HALF, // Reference half bit
  input wire logic [DATA_W-1:0] RX_PARALLEL_DATA, // Data out
  input wire logic RX_INTERFACE_CLOCK_OUT_TRUE, // Clock true
  input wire logic RX_INTERFACE_CLOCK_OUT_COMP, // Clock complement
  input wire logic RX_CLOCK_SOURCE_SELECT, // Source latch
  input wire logic RX_CLOCK_RATE_SELECT // Rate latch
);
  logic half_reg;
  wire src = RX_CLOCK_SOURCE_SELECT;
  wire ck = RX_INTERFACE_CLOCK_OUT_TRUE;
  wire sel_tick = src ? REF_EDGE_TICK : REC_EDGE_TICK;
  wire sel_rise = src ? REF_EDGE_RISE : REC_EDGE_RISE;
  wire copy_mode = src & half_reg;
  wire strobe = sel_tick & (sel_rise | copy_mode);
  wire div_mode = RX_CLOCK_RATE_SELECT & !copy_mode;
  always_ff @(posedge CLK) begin
    if (RST) half_reg <= REF_HALF_RST;
    else if (CFG_WRITE) half_reg <= CFG_REFCLK_HALF;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_div_rise;
    sel_tick && sel_rise && div_mode;
  endsequence
  sequence s_full_edge;
    sel_tick && !RX_CLOCK_RATE_SELECT && !copy_mode;
  endsequence
  a_comp_is_inverse: assert property (
    RX_INTERFACE_CLOCK_OUT_COMP == !ck) else $error("complement not inverse");
  a_data_on_strobe: assert property (
    $changed(RX_PARALLEL_DATA) |-> $past(strobe))
    else $error("data moved without clock edge");
  a_full_follows_edge: assert property (
    s_full_edge |=> ck == $past(sel_rise)) else $error("full rate level");
  a_half_toggles: assert property (
    s_div_rise |=> ck != $past(ck)) else $error("half rate no toggle");
  a_copy_follows_ref: assert property (
    sel_tick && copy_mode |=> ck == $past(REF_EDGE_RISE))
    else $error("reference copy level");
  a_clock_still: assert property (
    !sel_tick |=> $stable(ck)) else $error("clock moved without edge");
  a_latch_load: assert property (
    CFG_WRITE |=> src == $past(CFG_CLK_SRC_SEL)
    && RX_CLOCK_RATE_SELECT == $past(CFG_RATE_SEL)) else $error("latch load");
  a_latch_hold: assert property (
    !CFG_WRITE |=> $stable({src, RX_CLOCK_RATE_SELECT}))
    else $error("latch changed without write");
endmodule : rx_port_properties
bind rx_parallel_output_port rx_port_properties u_rx_port_properties (
  .CLK(CLK), .RST(RST), .REC_EDGE_TICK(REC_EDGE_TICK),
  .REC_EDGE_RISE(REC_EDGE_RISE), .REF_EDGE_TICK(REF_EDGE_TICK),
  .REF_EDGE_RISE(REF_EDGE_RISE), .CFG_WRITE(CFG_WRITE),
  .CFG_CLK_SRC_SEL(CFG_CLK_SRC_SEL), .CFG_RATE_SEL(CFG_RATE_SEL),
  .CFG_REFCLK_HALF(CFG_REFCLK_HALF), .RX_PARALLEL_DATA(RX_PARALLEL_DATA),
  .RX_INTERFACE_CLOCK_OUT_TRUE(RX_INTERFACE_CLOCK_OUT_TRUE),
  .RX_INTERFACE_CLOCK_OUT_COMP(RX_INTERFACE_CLOCK_OUT_COMP),
  .RX_CLOCK_SOURCE_SELECT(RX_CLOCK_SOURCE_SELECT),
  .RX_CLOCK_RATE_SELECT(RX_CLOCK_RATE_SELECT));
`default_nettype wire

/* host_capture_model.sv */
// Purpose: Host logic that captures port data on the interface clock rise.
// Assumes: The interface clock is a level sampled on the system clock.
// Notes: Half-rate falling-edge characters are not captured by this host.
`timescale 1ns/1ps
`default_nettype none
module host_capture_model
  import rx_port_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic rx_clk_true, // Port interface clock
  input wire logic [DATA_W-1:0] rx_data, // Port data
  output logic [DATA_W-1:0] cap_data_reg // Last captured character
);
  logic prev_reg;
  always_ff @(posedge clk) begin
    prev_reg <= rx_clk_true;
    if (rst) cap_data_reg <= DATA_RST;
    else if (rx_clk_true && !prev_reg) cap_data_reg <= rx_data;
  end
endmodule : host_capture_model
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the receive parallel output port.
// Assumes: Source clock edges are driven as one-cycle ticks.
// Notes: Each scenario leaves the clock level low for the next one.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rx_port_pkg::*;
  logic clk, rst, rtick, rrise, ftick, frise, cw, csrc, crate, chalf, cbyp;
  logic iv, cm, rdy_o, ck_t, ck_c, src_o, rate_o, miss_o;
  logic [9:0] raw;
  logic [7:0] dec, dat_o, cap;
  logic [2:0] st, sta_o;
  int err_total, checked, cyc;
  rx_parallel_output_port u_rx_parallel_output_port (.CLK(clk), .RST(rst),
    .REC_EDGE_TICK(rtick), .REC_EDGE_RISE(rrise), .REF_EDGE_TICK(ftick),
    .REF_EDGE_RISE(frise), .CFG_WRITE(cw), .CFG_CLK_SRC_SEL(csrc),
    .CFG_RATE_SEL(crate), .CFG_REFCLK_HALF(chalf), .CFG_DECODER_BYPASS(cbyp),
    .RX_IN_VALID(iv), .RX_IN_READY(rdy_o), .RX_IN_RAW(raw),
    .RX_IN_DECODED(dec), .RX_IN_STATUS_CODE(st), .RX_IN_IS_COMMA(cm),
    .RX_PARALLEL_DATA(dat_o), .RX_CHAR_STATUS(sta_o),
    .RX_INTERFACE_CLOCK_OUT_TRUE(ck_t), .RX_INTERFACE_CLOCK_OUT_COMP(ck_c),
    .RX_CLOCK_SOURCE_SELECT(src_o), .RX_CLOCK_RATE_SELECT(rate_o),
    .RX_CHAR_MISSED(miss_o));
  host_capture_model u_host_capture_model (.clk(clk), .rst(rst),
    .rx_clk_true(ck_t), .rx_data(dat_o), .cap_data_reg(cap));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic cfg(input logic s, input logic r, input logic h,
                     input logic b);
    @(posedge clk);
    {cw, csrc, crate, chalf, cbyp} <= {1'b1, s, r, h, b};
    @(posedge clk);
    cw <= 1'b0;
    @(posedge clk);
    #1;
    chk({src_o, rate_o}, {s, r});
  endtask : cfg
  task automatic push(input logic [9:0] r, input logic [7:0] d,
                      input logic [2:0] s, input logic c);
    logic rdy;
    int n;
    rdy = 1'b0;
    n = 0;
    @(posedge clk);
    {iv, raw, dec, st, cm} <= {1'b1, r, d, s, c};
    while (!rdy && n < 20) begin
      #1 rdy = rdy_o;
      @(posedge clk);
      n++;
    end
    iv <= 1'b0;
    chk(rdy, 1'b1);
  endtask : push
  // Drives one source edge, then waits until the outputs have settled
  task automatic tick(input logic use_ref, input logic r);
    @(posedge clk);
    if (use_ref) {ftick, frise} <= {1'b1, r};
    else {rtick, rrise} <= {1'b1, r};
    @(posedge clk);
    {ftick, rtick} <= 2'b00;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic t_fill_drain();
    for (int i = 0; i < 4; i++) push(10'h000, 8'h10 + i, 3'(i), 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(rdy_o, 1'b0);
    tick(1'b1, 1'b1);
    chk({dat_o, ck_t}, {8'h00, 1'b0});
    for (int i = 0; i < 4; i++) begin
      tick(1'b0, 1'b1);
      chk({dat_o, sta_o}, {8'(8'h10 + i), 3'(i)});
      chk({ck_t, ck_c, cap}, {2'b10, 8'(8'h10 + i)});
      tick(1'b0, 1'b0);
      chk({ck_t, dat_o}, {1'b0, 8'(8'h10 + i)});
    end
    chk(rdy_o, 1'b1);
    tick(1'b0, 1'b1);
    chk({miss_o, dat_o}, {1'b1, 8'h13});
    tick(1'b0, 1'b0);
  endtask : t_fill_drain
  task automatic t_bypass();
    cfg(1'b0, 1'b0, 1'b0, 1'b1);
    push(10'h2A7, 8'hFF, 3'h0, 1'b1);
    push(10'h155, 8'hFF, 3'h7, 1'b0);
    tick(1'b0, 1'b1);
    chk({dat_o, sta_o}, {8'hA9, 3'h7});
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b1);
    chk({dat_o, sta_o}, {8'h55, 3'h1});
    tick(1'b0, 1'b0);
  endtask : t_bypass
  task automatic t_divide();
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    push(10'h000, 8'hA0, 3'h2, 1'b0);
    push(10'h000, 8'hA1, 3'h3, 1'b0);
    tick(1'b0, 1'b1);
    chk({ck_t, dat_o}, {1'b1, 8'hA0});
    tick(1'b0, 1'b1);
    chk({ck_t, ck_c, dat_o}, {2'b01, 8'hA1});
  endtask : t_divide
  task automatic t_refcopy();
    cfg(1'b1, 1'b1, 1'b1, 1'b0);
    push(10'h000, 8'hC0, 3'h4, 1'b0);
    push(10'h000, 8'hC1, 3'h5, 1'b0);
    tick(1'b0, 1'b1);
    chk({ck_t, dat_o}, {1'b0, 8'hA1});
    tick(1'b1, 1'b1);
    chk({ck_t, dat_o, sta_o}, {1'b1, 8'hC0, 3'h4});
    tick(1'b1, 1'b0);
    chk({ck_t, dat_o, sta_o}, {1'b0, 8'hC1, 3'h5});
  endtask : t_refcopy
  // Full-rate reference: only its rising edges move data
  task automatic t_ref_follow();
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    push(10'h000, 8'hD0, 3'h6, 1'b0);
    tick(1'b0, 1'b1);
    chk({ck_t, dat_o}, {1'b0, 8'hC1});
    tick(1'b1, 1'b1);
    chk({ck_t, ck_c, dat_o, sta_o}, {2'b10, 8'hD0, 3'h6});
    tick(1'b1, 1'b0);
    chk({ck_t, dat_o, miss_o}, {1'b0, 8'hD0, 1'b0});
  endtask : t_ref_follow
  // Half-rate reference with recovered source still obeys the rate latch
  task automatic t_rec_divide();
    cfg(1'b0, 1'b1, 1'b1, 1'b0);
    push(10'h000, 8'hE0, 3'h1, 1'b0);
    push(10'h000, 8'hE1, 3'h2, 1'b0);
    tick(1'b1, 1'b1);
    chk({ck_t, dat_o}, {1'b0, 8'hD0});
    tick(1'b0, 1'b1);
    chk({ck_t, dat_o, sta_o}, {1'b1, 8'hE0, 3'h1});
    tick(1'b0, 1'b0);
    chk({ck_t, dat_o}, {1'b1, 8'hE0});
    tick(1'b0, 1'b1);
    chk({ck_t, ck_c, dat_o, sta_o}, {2'b01, 8'hE1, 3'h2});
  endtask : t_rec_divide
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    {rst, rtick, rrise, ftick, frise, cw, csrc, crate, chalf, cbyp} = 10'h200;
    {iv, cm, raw, dec, st} = 23'h000000;
    {err_total, checked, cyc} = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({dat_o, sta_o, ck_t, ck_c}, {8'h00, 3'h0, 2'b01});
    chk({src_o, rate_o, rdy_o, miss_o}, 4'h2);
    t_fill_drain();
    t_bypass();
    t_divide();
    t_refcopy();
    t_ref_follow();
    t_rec_divide();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
